// file: serial_slave_memory_port.sv
// Serial slave port giving a host access to the memory space and the
// flash, plus command posting to the microcontroller.
// Assumes memory and flash controllers answer on the system clock and
// that the host clock stops outside frames.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Read command, autoincrement, post unless 0x80
// - Write command, autoincrement outside mode, post unless 0x00
// - Interrupt enable bit, resets to zero
// - Interrupt flag set by hardware, written zero
// - Port enable bit connects pins, resets one
// - Write protect limits writes to window
// - Status bit 7 reports not ready
// - Status bit 6 parity of sent data
// - Status bit 5 parity of received bytes, status slot byte excluded
// - Status 4:2 count of bytes after command, short gives 111
// - Status bit 1 mode, bit 0 ready
// - Programming mode redirects accesses to flash
// - Flash writes are even-started word pairs
// - Single byte sets bank select in mode, large flash only
// - Mode halts controller, no interrupts, sticky
// - Entry needs emulation, boot, secure, unlock
// - Mode select then sequence key 0x96
// - Mass erase or read back codes only
// - Sequence write clears mode select
// - Entry disables engine, halts, resets flash
// - Idle while chip select high, output off
// - Address, command, status, then data bytes
// - Single byte always posts command, interrupts only outside mode
// - Protected window spans 0x400 to 0x40F
module serial_slave_memory_port
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clock_in,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  output logic port_enable,
  input wire logic mpu_wr,
  input wire logic mpu_sfr,
  input wire logic [15:0] mpu_addr,
  input wire logic [7:0] mpu_wdata,
  output logic [7:0] mpu_rdata,
  output logic port_irq,
  output logic mem_req,
  output logic mem_we,
  output logic mem_flash,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  output logic flash_word_req,
  output logic [15:0] flash_word_addr,
  output logic [15:0] flash_word_data,
  input wire logic flash_ready,
  input wire logic large_flash,
  output logic [1:0] flash_bank_select,
  input wire logic emulation_enable_pin,
  input wire logic test_pin,
  input wire logic boot_phase_flag,
  input wire logic secure_flag,
  input wire logic [3:0] flash_unlock_key,
  input wire logic mass_erase_done,
  output logic flash_programming_mode,
  output logic engine_disable,
  output logic mpu_halt,
  output logic flash_ctrl_reset,
  output logic mass_erase_req,
  output logic secure_clear
);
  import serial_port_pkg::*;

  typedef struct packed {
    logic [2:0] bits;
    logic [2:0] idx;
    logic [7:0] rx_sh;
    logic [7:0] rx_byte;
    logic tog;
    logic [7:0] tx_sh;
  } link_t;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] tog_s;
    logic [2:0] emu_s;
    logic [2:0] test_s;
    logic cs_lvl;
    logic tog_seen;
    phase_t phase;
    logic [15:0] cnt;
    logic [15:0] addr;
    logic [7:0] cmd;
    logic [7:0] rd_data;
    logic [7:0] sent;
    logic [7:0] lo_byte;
    logic err;
    logic rd_par;
    logic wr_par;
    logic [7:0] stat;
    logic [7:0] stat_out;
    logic [7:0] host_cmd;
    logic irq_flag;
    logic irq_en;
    logic port_en;
    logic wprot;
    logic [7:0] mode_sel;
    logic fpm;
    logic [1:0] bank;
    logic [7:0] mpu_rdata;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic fw_req;
    logic [15:0] fw_addr;
    logic [15:0] fw_data;
    logic fl_reset;
    logic erase_req;
    logic sec_clear;
  } sys_t;

  link_t lk_ff, nxt_lk;
  sys_t s_ff, nxt_s;
  logic out_ff;
  logic cs_eff;

  function automatic logic in_window(input logic [15:0] a);
    in_window = (a >= WINDOW_LO) && (a <= WINDOW_HI);
  endfunction

  // Starts a byte read, or flags not ready
  function automatic sys_t issue_read(input sys_t s);
    sys_t r;
    r = s;
    if (mem_ready) begin
      r.mem_req = 1'b1;
      r.mem_we = 1'b0;
      r.mem_addr = s.addr;
    end else begin
      r.err = 1'b1;
    end
    return r;
  endfunction

  // Disabled port looks like an idle chip select
  assign cs_eff = chip_select_n | ~s_ff.port_en;

  //////////////////////////////////////////////////////////////////////
  // Link domain: shift in on rising edge, shift out on falling edge

  always_comb begin
    nxt_lk = lk_ff;
    nxt_lk.rx_sh = {lk_ff.rx_sh[6:0], serial_data_in};
    nxt_lk.bits = lk_ff.bits + 3'h1;
    nxt_lk.tx_sh = {lk_ff.tx_sh[6:0], 1'b0};
    if (lk_ff.bits == BIT_LAST) begin
      nxt_lk.rx_byte = {lk_ff.rx_sh[6:0], serial_data_in};
      nxt_lk.tog = ~lk_ff.tog;
      if (lk_ff.idx != IDX_DATA) begin
        nxt_lk.idx = lk_ff.idx + 3'h1;
      end
      // Status after command, read data after that
      if (lk_ff.idx == IDX_CMD) begin
        nxt_lk.tx_sh = s_ff.stat_out;
      end else if (lk_ff.idx >= IDX_STATUS) begin
        nxt_lk.tx_sh = s_ff.rd_data;
      end else begin
        nxt_lk.tx_sh = 8'h00;
      end
    end
  end

  // Frame state is held cleared while chip select is high
  always_ff @(posedge serial_clock_in or posedge cs_eff) begin
    if (cs_eff) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  always_ff @(negedge serial_clock_in or posedge cs_eff) begin
    if (cs_eff) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= lk_ff.tx_sh[7];
    end
  end

  assign serial_data_out = out_ff;
  assign serial_data_out_en = ~cs_eff;

  //////////////////////////////////////////////////////////////////////
  // System domain

  always_comb begin
    logic byte_ev;
    logic [7:0] b;
    logic [15:0] idx;
    logic [15:0] data_cnt;
    logic post;
    byte_ev = 1'b0;
    b = lk_ff.rx_byte;
    idx = s_ff.cnt;
    data_cnt = 16'h0000;
    post = 1'b0;
    nxt_s = s_ff;
    nxt_s.mem_req = 1'b0;
    nxt_s.fw_req = 1'b0;
    nxt_s.fl_reset = 1'b0;
    nxt_s.erase_req = 1'b0;
    nxt_s.sec_clear = mass_erase_done;

    // Three-stage synchronisers; chip select and toggle change taken when stages two and three agree
    nxt_s.cs_s = {s_ff.cs_s[1:0], cs_eff};
    nxt_s.tog_s = {s_ff.tog_s[1:0], lk_ff.tog};
    nxt_s.emu_s = {s_ff.emu_s[1:0], emulation_enable_pin};
    nxt_s.test_s = {s_ff.test_s[1:0], test_pin};
    if (s_ff.cs_s[1] == s_ff.cs_s[2]) begin
      nxt_s.cs_lvl = s_ff.cs_s[2];
    end
    if (s_ff.tog_s[1] == s_ff.tog_s[2] && s_ff.tog_s[2] != s_ff.tog_seen) begin
      nxt_s.tog_seen = s_ff.tog_s[2];
      // Chip select rise also clears the toggle; that is no byte
      byte_ev = (s_ff.phase == PH_FRAME) && !s_ff.cs_s[1] && !s_ff.cs_s[2];
    end

    // Status byte follows live flags only between frames
    if (s_ff.phase == PH_IDLE) begin
      nxt_s.stat_out = s_ff.stat;
      nxt_s.stat_out[ST_FLASH_MODE] = s_ff.fpm & s_ff.test_s[2];
      nxt_s.stat_out[ST_FLASH_READY] = flash_ready;
    end

    if (mem_rvalid) begin
      nxt_s.rd_data = mem_rdata;
    end

    // Received byte handling
    if (byte_ev) begin
      nxt_s.cnt = s_ff.cnt + 16'h0001;
      if (idx != {13'h0000, IDX_STATUS}) begin
        nxt_s.wr_par = nxt_s.wr_par ^ (^b);
      end
      case (idx)
        {13'h0000, IDX_ADDR_HI}: begin
          nxt_s.addr[15:8] = b;
        end
        {13'h0000, IDX_ADDR_LO}: begin
          nxt_s.addr[7:0] = b;
        end
        {13'h0000, IDX_CMD}: begin
          nxt_s.cmd = b;
          if (b[7]) begin
            nxt_s = issue_read(nxt_s);
          end
        end
        default: begin
          if (s_ff.cmd[7]) begin
            // Read: count the byte just sent, prefetch the next one
            if (idx >= CNT_DATA) begin
              nxt_s.rd_par = nxt_s.rd_par ^ (^s_ff.sent);
            end
            nxt_s.sent = s_ff.rd_data;
            nxt_s.addr = s_ff.addr + 16'h0001;
            nxt_s = issue_read(nxt_s);
          end else if (idx >= CNT_DATA) begin
            if (s_ff.fpm) begin
              // Word pairs, no address advance
              if (!idx[0]) begin
                nxt_s.lo_byte = b;
              end else if (flash_ready) begin
                nxt_s.fw_req = 1'b1;
                nxt_s.fw_addr = s_ff.addr;
                nxt_s.fw_data = {b, s_ff.lo_byte};
              end else begin
                nxt_s.err = 1'b1;
              end
            end else begin
              nxt_s.addr = s_ff.addr + 16'h0001;
              if (s_ff.wprot && !in_window(s_ff.addr)) begin
                nxt_s.err = nxt_s.err;
              end else if (s_ff.addr == IO_MODE_SELECT) begin
                nxt_s.mode_sel = b;
              end else if (s_ff.addr == IO_MODE_SEQUENCE) begin
                nxt_s.mode_sel = 8'h00;
                if (b == SEQ_KEY && s_ff.emu_s[2] && !boot_phase_flag &&
                    flash_unlock_key == UNLOCK_KEY &&
                    (s_ff.mode_sel == MODE_MASS_ERASE ||
                     (s_ff.mode_sel == MODE_READ_BACK && !secure_flag))) begin
                  nxt_s.fpm = 1'b1;
                  nxt_s.fl_reset = 1'b1;
                  nxt_s.erase_req = (s_ff.mode_sel == MODE_MASS_ERASE);
                end
              end else if (mem_ready) begin
                nxt_s.mem_req = 1'b1;
                nxt_s.mem_we = 1'b1;
                nxt_s.mem_addr = s_ff.addr;
                nxt_s.mem_wdata = b;
              end else begin
                nxt_s.err = 1'b1;
              end
            end
          end
        end
      endcase
    end

    // Frame phase
    case (s_ff.phase)
      PH_IDLE: begin
        if (!s_ff.cs_lvl) begin
          nxt_s.phase = PH_FRAME;
          nxt_s.cnt = 16'h0000;
          nxt_s.cmd = 8'h00;
          nxt_s.err = 1'b0;
          nxt_s.rd_par = 1'b0;
          nxt_s.wr_par = 1'b0;
        end
      end
      PH_FRAME: begin
        if (s_ff.cs_lvl) begin
          nxt_s.phase = PH_IDLE;
          if (nxt_s.cnt > CNT_STATUS) begin
            data_cnt = nxt_s.cnt - CNT_HEADER;
          end
          nxt_s.stat[ST_NOT_READY] = nxt_s.err;
          nxt_s.stat[ST_READ_PAR] = nxt_s.rd_par;
          nxt_s.stat[ST_WRITE_PAR] = nxt_s.wr_par;
          nxt_s.stat[ST_COUNT_HI:ST_COUNT_LO] =
            (nxt_s.cnt > CNT_STATUS) ? data_cnt[2:0] : SHORT_COUNT;
          if (nxt_s.cnt == CNT_SINGLE) begin
            nxt_s.host_cmd = nxt_s.addr[15:8];
            post = 1'b1;
            if (s_ff.fpm && large_flash) begin
              nxt_s.bank = nxt_s.addr[9:8];
            end
          end else if (nxt_s.cnt >= CNT_HEADER &&
                       nxt_s.cmd[6:0] != CMD_SILENT) begin
            nxt_s.host_cmd = nxt_s.cmd;
            post = 1'b1;
          end
        end
      end
      default: begin
        nxt_s.phase = PH_IDLE;
      end
    endcase

    // Controller register writes; a clear loses to a same-cycle set
    if (mpu_wr && mpu_sfr && mpu_addr[7:0] == SFR_IRQ_FLAG &&
        !mpu_wdata[IRQ_FLAG_BIT]) begin
      nxt_s.irq_flag = 1'b0;
    end
    if (mpu_wr && !mpu_sfr && mpu_addr == IO_IRQ_ENABLE) begin
      nxt_s.irq_en = mpu_wdata[IRQ_ENABLE_BIT];
    end
    if (mpu_wr && !mpu_sfr && mpu_addr == IO_PORT_CTRL) begin
      nxt_s.port_en = mpu_wdata[PORT_ENABLE_BIT];
      nxt_s.wprot = mpu_wdata[WRITE_PROTECT_BIT];
    end
    if (post && !s_ff.fpm) begin
      nxt_s.irq_flag = 1'b1;
    end

    // Controller register reads, one cycle behind the address
    nxt_s.mpu_rdata = 8'h00;
    if (mpu_sfr) begin
      if (mpu_addr[7:0] == SFR_IRQ_FLAG) begin
        nxt_s.mpu_rdata[IRQ_FLAG_BIT] = s_ff.irq_flag;
      end else if (mpu_addr[7:0] == SFR_HOST_CMD) begin
        nxt_s.mpu_rdata = s_ff.host_cmd;
      end
    end else if (mpu_addr == IO_IRQ_ENABLE) begin
      nxt_s.mpu_rdata[IRQ_ENABLE_BIT] = s_ff.irq_en;
    end else if (mpu_addr == IO_STATUS) begin
      nxt_s.mpu_rdata = s_ff.stat_out;
    end else if (mpu_addr == IO_PORT_CTRL) begin
      nxt_s.mpu_rdata[PORT_ENABLE_BIT] = s_ff.port_en;
      nxt_s.mpu_rdata[WRITE_PROTECT_BIT] = s_ff.wprot;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.cs_s <= 3'h7;
      s_ff.cs_lvl <= 1'b1;
      s_ff.phase <= PH_IDLE;
      s_ff.port_en <= PORT_ENABLE_RST;
      s_ff.wprot <= WRITE_PROTECT_RST;
      s_ff.irq_en <= IRQ_ENABLE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign port_enable = s_ff.port_en;
  assign mpu_rdata = s_ff.mpu_rdata;
  assign port_irq = s_ff.irq_flag & s_ff.irq_en;
  assign mem_req = s_ff.mem_req;
  assign mem_we = s_ff.mem_we;
  assign mem_flash = s_ff.fpm;
  assign mem_addr = s_ff.mem_addr;
  assign mem_wdata = s_ff.mem_wdata;
  assign flash_word_req = s_ff.fw_req;
  assign flash_word_addr = s_ff.fw_addr;
  assign flash_word_data = s_ff.fw_data;
  assign flash_bank_select = s_ff.bank;
  assign flash_programming_mode = s_ff.fpm;
  assign engine_disable = s_ff.fpm;
  assign mpu_halt = s_ff.fpm;
  assign flash_ctrl_reset = s_ff.fl_reset;
  assign mass_erase_req = s_ff.erase_req;
  assign secure_clear = s_ff.sec_clear;

endmodule

`default_nettype wire

// file: serial_port_pkg.sv
// Constants, register map and types for the serial slave memory port.
// Assumes a single system clock domain plus the host-driven serial clock.
`default_nettype none

package serial_port_pkg;

  // Register locations, SFR space
  localparam logic [7:0] SFR_IRQ_FLAG = 8'hF8;
  localparam logic [7:0] SFR_HOST_CMD = 8'hFD;
  localparam int IRQ_FLAG_BIT = 7;
  // Register locations, I/O RAM space
  localparam logic [15:0] IO_IRQ_ENABLE = 16'h2701;
  localparam logic [15:0] IO_STATUS = 16'h2708;
  localparam logic [15:0] IO_PORT_CTRL = 16'h270C;
  localparam logic [15:0] IO_MODE_SELECT = 16'h2080;
  localparam logic [15:0] IO_MODE_SEQUENCE = 16'h2081;
  localparam int IRQ_ENABLE_BIT = 7;
  localparam int PORT_ENABLE_BIT = 4;
  localparam int WRITE_PROTECT_BIT = 3;

  // Reset values
  localparam logic PORT_ENABLE_RST = 1'b1;
  localparam logic WRITE_PROTECT_RST = 1'b0;
  localparam logic IRQ_ENABLE_RST = 1'b0;

  // Protected write window
  localparam logic [15:0] WINDOW_LO = 16'h0400;
  localparam logic [15:0] WINDOW_HI = 16'h040F;

  // Status byte fields
  localparam int ST_NOT_READY = 7;
  localparam int ST_READ_PAR = 6;
  localparam int ST_WRITE_PAR = 5;
  localparam int ST_COUNT_HI = 4;
  localparam int ST_COUNT_LO = 2;
  localparam int ST_FLASH_MODE = 1;
  localparam int ST_FLASH_READY = 0;
  localparam logic [2:0] SHORT_COUNT = 3'h7;

  // Command codes and flash entry codes
  localparam logic [6:0] CMD_SILENT = 7'h00;
  localparam logic [7:0] MODE_MASS_ERASE = 8'hD1;
  localparam logic [7:0] MODE_READ_BACK = 8'h2E;
  localparam logic [7:0] SEQ_KEY = 8'h96;
  localparam logic [3:0] UNLOCK_KEY = 4'h2;

  // Byte positions within a frame
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] IDX_ADDR_HI = 3'h0;
  localparam logic [2:0] IDX_ADDR_LO = 3'h1;
  localparam logic [2:0] IDX_CMD = 3'h2;
  localparam logic [2:0] IDX_STATUS = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [15:0] CNT_SINGLE = 16'h0001;
  localparam logic [15:0] CNT_HEADER = 16'h0003;
  localparam logic [15:0] CNT_STATUS = 16'h0003;
  localparam logic [15:0] CNT_DATA = 16'h0004;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_FRAME = 2'b10
  } phase_t;

endpackage

`default_nettype wire

// file: serial_port_properties.sv
// Concurrent checks on the serial slave memory port top ports.
// Bound to every port instance; system clock domain only.
`timescale 1ns/1ps
`default_nettype none
module serial_port_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic serial_data_out_en,
  input wire logic port_enable,
  input wire logic port_irq,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_flash,
  input wire logic flash_word_req,
  input wire logic [15:0] flash_word_addr,
  input wire logic mass_erase_done,
  input wire logic secure_clear,
  input wire logic flash_programming_mode,
  input wire logic mpu_halt,
  input wire logic engine_disable,
  input wire logic flash_ctrl_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_reset_pulse;
    flash_ctrl_reset ##1 !flash_ctrl_reset;
  endsequence
  property p_pin_drive;
    serial_data_out_en == (!chip_select_n && port_enable);
  endproperty
  property p_reset_state;
    $fell(rst) |-> port_enable && !flash_programming_mode && !mpu_halt;
  endproperty
  property p_mode_sticky;
    flash_programming_mode |=> flash_programming_mode;
  endproperty
  property p_mode_halts;
    flash_programming_mode |=> mpu_halt && engine_disable;
  endproperty
  property p_entry_reset;
    flash_ctrl_reset |-> s_reset_pulse ##[0:1] flash_programming_mode;
  endproperty
  property p_no_irq;
    flash_programming_mode && !port_irq |=> !port_irq;
  endproperty
  property p_mem_target;
    mem_req |-> mem_flash == flash_programming_mode && !(mem_flash && mem_we);
  endproperty
  property p_word_even;
    flash_word_req |-> !flash_word_addr[0] && flash_programming_mode;
  endproperty
  property p_secure_clear;
    mass_erase_done |=> secure_clear;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin enable");
  a_reset_state: assert property (p_reset_state) else $error("reset");
  a_mode_sticky: assert property (p_mode_sticky) else $error("mode");
  a_mode_halts: assert property (p_mode_halts) else $error("halt");
  a_entry_reset: assert property (p_entry_reset) else $error("fl rst");
  a_no_irq: assert property (p_no_irq) else $error("irq in mode");
  a_mem_target: assert property (p_mem_target) else $error("target");
  a_word_even: assert property (p_word_even) else $error("word");
  a_secure_clear: assert property (p_secure_clear) else $error("sec");
endmodule
bind serial_slave_memory_port serial_port_properties u_props (
  .clk, .rst, .chip_select_n, .serial_data_out_en, .port_enable, .port_irq,
  .mem_req, .mem_we, .mem_flash, .flash_word_req, .flash_word_addr,
  .mass_erase_done,
  .secure_clear, .flash_programming_mode, .mpu_halt, .engine_disable,
  .flash_ctrl_reset
);
`default_nettype wire

// file: serial_host_model.sv
// Host master model: frames of bytes on the serial link.
// Assumes the bench fills tx, calls run, then reads rx.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  output logic serial_clock_in,
  output logic chip_select_n,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  logic [7:0] tx [8];
  logic [7:0] rx [8];
  initial begin
    serial_clock_in = 1'b0;
    chip_select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // Link clock runs only inside a frame, 80 ns period
  task automatic run(input int n);
    #3.3;
    chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        serial_data_in = tx[i][b];
        #40 serial_clock_in = 1'b1;
        rx[i][b] = serial_data_out;
        #40 serial_clock_in = 1'b0;
      end
    end
    #60 chip_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #150;
  endtask
endmodule
`default_nettype wire

// file: serial_slave_memory_port_tb.sv
// Self-checking bench for the serial slave memory port.
// Assumes the host model and property checker compile before it.
`timescale 1ns/1ps
`default_nettype none
module serial_slave_memory_port_tb;
  import serial_port_pkg::*;
  typedef struct packed {
    logic wr;
    logic sfr;
    logic [15:0] a;
    logic [7:0] d;
    logic [7:0] m;
  } row_t;
  localparam logic [15:0] FLAG_LOC = {8'h00, SFR_IRQ_FLAG};
  localparam logic [15:0] CMD_LOC = {8'h00, SFR_HOST_CMD};
  logic clk = 1'b0;
  logic rst, serial_clock_in, chip_select_n, serial_data_in;
  logic serial_data_out, serial_data_out_en, port_enable, mpu_wr, mpu_sfr;
  logic [15:0] mpu_addr, mem_addr, flash_word_addr, flash_word_data, wr_a;
  logic [7:0] mpu_wdata, mpu_rdata, mem_wdata, mem_rdata, wr_d, sel, v;
  logic port_irq, mem_req, mem_we, mem_flash, mem_ready, mem_rvalid;
  logic flash_word_req, flash_ready, large_flash, emulation_enable_pin;
  logic test_pin, boot_phase_flag, secure_flag, mass_erase_done, in_mode;
  logic flash_programming_mode, engine_disable, mpu_halt, flash_ctrl_reset;
  logic mass_erase_req, secure_clear, exp_err;
  logic [1:0] flash_bank_select;
  logic [3:0] flash_unlock_key;
  logic [5:0] prev_st;
  logic [31:0] fw;
  int fail_count, checks_done, cycles, wr_n, fw_n, ers_n;
  row_t rows [10];
  always #5 clk = ~clk;
  serial_slave_memory_port dut (.clk, .rst, .serial_clock_in,
    .chip_select_n, .serial_data_in, .serial_data_out, .serial_data_out_en,
    .port_enable, .mpu_wr, .mpu_sfr, .mpu_addr, .mpu_wdata, .mpu_rdata,
    .port_irq, .mem_req, .mem_we, .mem_flash, .mem_addr, .mem_wdata,
    .mem_ready, .mem_rvalid, .mem_rdata, .flash_word_req, .flash_word_addr,
    .flash_word_data, .flash_ready, .large_flash, .flash_bank_select,
    .emulation_enable_pin, .test_pin, .boot_phase_flag, .secure_flag,
    .flash_unlock_key, .mass_erase_done, .flash_programming_mode,
    .engine_disable, .mpu_halt, .flash_ctrl_reset, .mass_erase_req,
    .secure_clear);
  serial_host_model host (.serial_clock_in, .chip_select_n,
    .serial_data_in, .serial_data_out);
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_wr(input logic s, input logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    mpu_wr <= 1'b1;
    mpu_sfr <= s;
    mpu_addr <= a;
    mpu_wdata <= d;
    @(posedge clk);
    mpu_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic s, input logic [15:0] a);
    @(posedge clk);
    mpu_sfr <= s;
    mpu_addr <= a;
    @(posedge clk);
    #1 v = mpu_rdata;
  endtask
  // One frame; checks status out, status register and mode
  task automatic frame(input int n, input logic [15:0] a,
      input logic [7:0] c, d0, d1);
    logic [7:0] rd;
    logic dp;
    logic hp;
    host.tx[0] = (n == 1) ? c : a[15:8];
    host.tx[1] = a[7:0];
    host.tx[2] = c;
    host.tx[3] = 8'h00;
    host.tx[4] = d0;
    host.tx[5] = d1;
    host.run(n);
    if (n > 3)
      chk(host.rx[3], {prev_st, in_mode & test_pin, 1'b1}, "st");
    hp = (n == 1) ? ^c : ^{a, c, d0 & {8{n > 4}}, d1 & {8{n > 5}}};
    dp = 1'b0;
    for (int k = 4; k < n && c[7]; k++) begin
      rd = (a[7:0] + 8'(k - 4)) ^ 8'h5A;
      chk(host.rx[k], rd, "read data");
      dp ^= ^rd;
    end
    prev_st = {exp_err, dp, hp, (n > 3) ? 3'(n - 3) : SHORT_COUNT};
    if (n > 4 && !c[7] && a == IO_MODE_SELECT) sel = d0;
    if (n > 4 && !c[7] && a == IO_MODE_SEQUENCE) begin
      in_mode |= d0 == SEQ_KEY && (sel == MODE_MASS_ERASE ||
        sel == MODE_READ_BACK && !secure_flag);
      sel = 8'h00;
    end
    reg_rd(1'b0, IO_STATUS);
    chk(v, {prev_st, in_mode & test_pin, 1'b1}, "status");
    chk(flash_programming_mode, in_mode, "mode");
  endtask
  task automatic post(input logic [7:0] c, input logic f);
    reg_rd(1'b1, CMD_LOC);
    chk(v, c, "host command");
    reg_rd(1'b1, FLAG_LOC);
    chk(v[IRQ_FLAG_BIT], f, "irq flag");
    chk(port_irq, f, "irq line");
    reg_wr(1'b1, FLAG_LOC, 8'h00);
  endtask
  task automatic enter(input logic [7:0] s, q);
    frame(5, IO_MODE_SELECT, 8'h00, s, 8'h00);
    frame(5, IO_MODE_SEQUENCE, 8'h00, q, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    mem_rvalid <= mem_req && !mem_we;
    mem_rdata <= mem_addr[7:0] ^ 8'h5A;
    if (mem_req && mem_we) begin
      wr_n <= wr_n + 1;
      wr_a <= mem_addr;
      wr_d <= mem_wdata;
    end
    if (flash_word_req) begin
      fw_n <= fw_n + 1;
      fw <= {flash_word_addr, flash_word_data};
    end
    if (mass_erase_req) ers_n <= ers_n + 1;
    if (cycles == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    rst = 1'b1;
    mpu_wr = 1'b0;
    mpu_sfr = 1'b0;
    mpu_addr = 16'h0000;
    mpu_wdata = 8'h00;
    mem_ready = 1'b1;
    mem_rvalid = 1'b0;
    mem_rdata = 8'h00;
    flash_ready = 1'b1;
    large_flash = 1'b1;
    emulation_enable_pin = 1'b1;
    test_pin = 1'b0;
    boot_phase_flag = 1'b0;
    secure_flag = 1'b0;
    flash_unlock_key = UNLOCK_KEY;
    mass_erase_done = 1'b0;
    prev_st = 6'h00;
    sel = 8'h00;
    in_mode = 1'b0;
    exp_err = 1'b0;
    rows = '{'{1'b0, 1'b0, IO_STATUS, 8'h00, 8'hFC},
      '{1'b0, 1'b0, IO_IRQ_ENABLE, 8'h00, 8'h80},
      '{1'b0, 1'b0, IO_PORT_CTRL, 8'h10, 8'h18},
      '{1'b0, 1'b1, FLAG_LOC, 8'h00, 8'h80},
      '{1'b1, 1'b0, IO_IRQ_ENABLE, 8'h80, 8'h00},
      '{1'b0, 1'b0, IO_IRQ_ENABLE, 8'h80, 8'h80},
      '{1'b1, 1'b0, IO_PORT_CTRL, 8'h08, 8'h00},
      '{1'b0, 1'b0, IO_PORT_CTRL, 8'h08, 8'h18},
      '{1'b1, 1'b0, IO_PORT_CTRL, 8'h10, 8'h00},
      '{1'b0, 1'b0, 16'h1234, 8'h00, 8'hFF}};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].wr) reg_wr(rows[i].sfr, rows[i].a, rows[i].d);
      else begin
        reg_rd(rows[i].sfr, rows[i].a);
        chk(v & rows[i].m, rows[i].d, "register");
      end
    end
    $display("test registers done");
    frame(6, 16'h0123, 8'h81, 8'h00, 8'h00);
    post(8'h81, 1'b1);
    frame(5, 16'h0200, 8'h80, 8'h00, 8'h00);
    post(8'h81, 1'b0);
    $display("test reads done");
    frame(6, 16'h0400, 8'h01, 8'hA5, 8'h3C);
    chk(16'(wr_n), 16'h0002, "write count");
    chk(wr_a, 16'h0401, "write address");
    chk(wr_d, 8'h3C, "write data");
    post(8'h01, 1'b1);
    reg_wr(1'b0, IO_PORT_CTRL, 8'h18);
    frame(5, 16'h0500, 8'h00, 8'h66, 8'h00);
    chk(16'(wr_n), 16'h0002, "protected write");
    post(8'h01, 1'b0);
    frame(5, 16'h040F, 8'h02, 8'h77, 8'h00);
    chk(wr_a, 16'h040F, "window address");
    chk(wr_d, 8'h77, "window data");
    post(8'h02, 1'b1);
    frame(1, 16'h0000, 8'h00, 8'h00, 8'h00);
    post(8'h00, 1'b1);
    @(posedge clk) mem_ready <= 1'b0;
    exp_err = 1'b1;
    frame(5, 16'h0401, 8'h00, 8'h55, 8'h00);
    exp_err = 1'b0;
    @(posedge clk) mem_ready <= 1'b1;
    reg_wr(1'b0, IO_PORT_CTRL, 8'h10);
    $display("test writes done");
    test_pin <= 1'b1;
    secure_flag <= 1'b1;
    enter(MODE_READ_BACK, SEQ_KEY);
    secure_flag <= 1'b0;
    enter(8'h2F, SEQ_KEY);
    enter(MODE_READ_BACK, 8'h95);
    frame(5, IO_MODE_SEQUENCE, 8'h00, SEQ_KEY, 8'h00);
    enter(MODE_READ_BACK, SEQ_KEY);
    chk(mpu_halt, 1'b1, "halt");
    chk(engine_disable, 1'b1, "engine");
    frame(6, 16'h0010, 8'h00, 8'h34, 8'h12);
    chk(16'(fw_n), 16'h0001, "word count");
    chk(fw[31:16], 16'h0010, "word address");
    chk(fw[15:0], 16'h1234, "word data");
    frame(6, 16'h0020, 8'h80, 8'h00, 8'h00);
    frame(4, 16'h0000, 8'h00, 8'h00, 8'h00);
    frame(1, 16'h0000, 8'h03, 8'h00, 8'h00);
    chk(flash_bank_select, 2'b11, "bank");
    chk(port_irq, 1'b0, "no irq");
    test_pin <= 1'b0;
    repeat (5) @(posedge clk);
    reg_rd(1'b0, IO_STATUS);
    chk(v[ST_FLASH_MODE], 1'b0, "mode bit, test low");
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    in_mode = 1'b0;
    prev_st = 6'h00;
    repeat (4) @(posedge clk);
    chk(flash_programming_mode, 1'b0, "mode after reset");
    secure_flag <= 1'b1;
    enter(MODE_MASS_ERASE, SEQ_KEY);
    chk(16'(ers_n), 16'h0001, "mass erase");
    @(posedge clk) mass_erase_done <= 1'b1;
    @(posedge clk) mass_erase_done <= 1'b0;
    #1 chk(secure_clear, 1'b1, "secure clear");
    repeat (3) @(posedge clk);
    $display("test flash mode done");
    finish_test();
  end
endmodule
`default_nettype wire
